// ===== common/bcl_consts.svh
// constants for the boot configuration latch block
`ifndef BCL_CONSTS_SVH
`define BCL_CONSTS_SVH
// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define BCL_IDX_DRIVE_LOW      4'h0
`define BCL_IDX_DRIVE_HIGH     4'h1
`define BCL_IDX_PIN_DEBUG      4'h2
`define BCL_IDX_CLOCK_ECC      4'h3
`define BCL_IDX_ACTIVE_LOW     4'h4
`define BCL_IDX_ACTIVE_HIGH    4'h5
`define BCL_IDX_ACTIVE_PIN     4'h6
`define BCL_IDX_ACTIVE_CLOCK   4'h7
`define BCL_IDX_STATUS         4'h8
// ----------------------------------------------------------------
// factory defaults of the four latch bytes
// ----------------------------------------------------------------
`define BCL_DEF_DRIVE_LOW      8'h00
`define BCL_DEF_DRIVE_HIGH     8'h00
`define BCL_DEF_PIN_DEBUG      8'h40
`define BCL_DEF_CLOCK_ECC      8'h0a
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BCL_BIT_EXT_RESET      7
`define BCL_BIT_DEBUG_EN       6
`define BCL_BIT_ECC_EN         3
`define BCL_BIT_BOOT_SPEED     0
`define BCL_PHASE_MSB          7
`define BCL_PHASE_LSB          4
`define BCL_DPS_MSB            2
`define BCL_DPS_LSB            1
`define BCL_BYTE2_USED_MASK    8'hc3
`define BCL_NUM_PORTS          9
`define BCL_LATCH_BYTES        4
// ----------------------------------------------------------------
// boot oscillator frequencies in MHz
// ----------------------------------------------------------------
`define BCL_BOOT_MHZ_SLOW      8'h0c
`define BCL_BOOT_MHZ_FAST      8'h30
`endif

// ===== common/bcl_pkg.sv
// types for the boot configuration latch block
package bcl_pkg;
    typedef enum logic [1:0] {
        BCL_DRV_HIZ_ANALOG  = 2'b00,
        BCL_DRV_HIZ_DIGITAL = 2'b01,
        BCL_DRV_PULL_UP     = 2'b10,
        BCL_DRV_PULL_DOWN   = 2'b11
    } bcl_drive_t;
    typedef enum logic [1:0] {
        BCL_DBG_JTAG5 = 2'b00,
        BCL_DBG_JTAG4 = 2'b01,
        BCL_DBG_SWD   = 2'b10,
        BCL_DBG_NONE  = 2'b11
    } bcl_dbg_port_t;
    typedef enum logic [1:0] {
        BCL_ST_RESET = 2'b00,
        BCL_ST_LOAD  = 2'b01,
        BCL_ST_RUN   = 2'b10
    } bcl_state_t;
    typedef struct packed {
        bcl_drive_t [8:0] port_reset_drive_mode;
        logic             external_reset_pin_select;
        logic             debug_access_enable;
        bcl_dbg_port_t    debug_port_select;
        logic             spare_flash_ecc_enable;
        logic             boot_clock_speed;
        logic [3:0]       digital_clock_phase_delay;
    } bcl_config_t;
    typedef struct packed {
        logic [7:0] drive_low;
        logic [7:0] drive_high;
        logic [7:0] pin_debug;
        logic [7:0] clock_ecc;
    } bcl_latch_t;
    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } bcl_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } bcl_apb_rsp_t;
endpackage

// ===== hw/bcl_decode.sv
// decodes four latch bytes into the device configuration fields
`timescale 1ns/1ps
`include "bcl_consts.svh"
module bcl_decode (
    input  wire bcl_pkg::bcl_latch_t   latch,
    output bcl_pkg::bcl_config_t       cfg
);
    import bcl_pkg::*;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cfg.port_reset_drive_mode[i]   = bcl_drive_t'(latch.drive_low[2*i +: 2]);
            cfg.port_reset_drive_mode[i+4] = bcl_drive_t'(latch.drive_high[2*i +: 2]);
        end
        cfg.port_reset_drive_mode[8]     = bcl_drive_t'(latch.pin_debug[1:0]);
        // field placement in bytes 2 and 3
        cfg.external_reset_pin_select    = latch.pin_debug[`BCL_BIT_EXT_RESET];
        cfg.debug_access_enable          = latch.pin_debug[`BCL_BIT_DEBUG_EN];
        // phase code passes through undecoded; its meaning lies downstream
        cfg.digital_clock_phase_delay    = latch.clock_ecc[`BCL_PHASE_MSB:`BCL_PHASE_LSB];
        cfg.spare_flash_ecc_enable       = latch.clock_ecc[`BCL_BIT_ECC_EN];
        cfg.debug_port_select            =
            bcl_dbg_port_t'(latch.clock_ecc[`BCL_DPS_MSB:`BCL_DPS_LSB]);
        cfg.boot_clock_speed             = latch.clock_ecc[`BCL_BIT_BOOT_SPEED];
    end
endmodule

// ===== hw/bcl_top.sv
// boot configuration latch array with apb access and reset-time sampling
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "bcl_consts.svh"
// Behaviour
// - four nonvolatile latch bytes configure the device on leaving reset; here every presetn assertion reloads their factory defaults
// - each two-bit port field selects analog, digital, pull-up or pull-down reset drive
// - reset-select bit: 0 shared pin is gpio, 1 it is external reset input
// - debug-access bit: 0 blocks debug, 1 allows it; default 1
// - boot-speed bit: 0 selects 12 MHz, 1 selects 48 MHz boot oscillator
// - debug port field: five-wire jtag, four-wire jtag, swd, or none
// - ecc bit: 0 spare flash is data storage, 1 it holds ecc; default 1
// - four-bit field selects digital clock phase delay
module bcl_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [31:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    output bcl_pkg::bcl_config_t      cfg_active,
    output logic                      cfg_valid,
    output logic [7:0]                boot_clock_mhz
);
    import bcl_pkg::*;

    // every check in this block runs on pclk and sleeps while presetn is low
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        bcl_state_t  state;
        bcl_latch_t  latch;
        bcl_latch_t  snap;
        bcl_config_t cfg;
        logic        valid;
        logic [7:0]  mhz;
        logic [15:0] writes;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } bcl_st_t;

    bcl_st_t     st_reg;
    bcl_st_t     st_next;
    bcl_config_t dec_cfg;

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    function automatic logic [3:0] reg_index(input logic [31:0] a);
        return a[5:2];
    endfunction

    function automatic logic [31:0] reg_addr(input logic [3:0] i);
        return {26'h0, i, 2'b00};
    endfunction

    // the decoder sees the latches as sampled at reset, not live contents
    bcl_decode u_decode (
        .latch (st_reg.snap),
        .cfg   (dec_cfg)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic       acc;
    logic       hit;
    logic [3:0] idx;
    logic       wr_acc;

    always_comb begin
        st_next = st_reg;
        idx     = reg_index(paddr);
        acc     = psel && penable && !st_reg.ready;
        hit     = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'b00)
                  && (idx <= `BCL_IDX_STATUS);
        st_next.ready = 1'b0;
        st_next.err   = 1'b0;
        case (st_reg.state)
            BCL_ST_RESET: begin
                st_next.state = BCL_ST_LOAD;
            end
            BCL_ST_LOAD: begin
                // one-time capture after reset release
                st_next.snap  = st_reg.latch;
                st_next.state = BCL_ST_RUN;
            end
            BCL_ST_RUN: begin
                st_next.cfg   = dec_cfg;
                st_next.valid = 1'b1;
                st_next.mhz   = dec_cfg.boot_clock_speed ? `BCL_BOOT_MHZ_FAST
                                                         : `BCL_BOOT_MHZ_SLOW;
            end
            default: begin
                st_next.state = BCL_ST_RESET;
            end
        endcase
        if (acc) begin
            st_next.ready = 1'b1;
            st_next.err   = !hit || (pwrite && idx > `BCL_IDX_CLOCK_ECC);
            st_next.rdata = 32'h0000_0000;
            if (hit && pwrite) begin
                // writes reprogram the array only; live config waits for reset
                case (idx)
                    `BCL_IDX_DRIVE_LOW:  st_next.latch.drive_low  = pwdata[7:0];
                    `BCL_IDX_DRIVE_HIGH: st_next.latch.drive_high = pwdata[7:0];
                    `BCL_IDX_PIN_DEBUG:  st_next.latch.pin_debug  =
                        pwdata[7:0] & `BCL_BYTE2_USED_MASK;
                    `BCL_IDX_CLOCK_ECC:  st_next.latch.clock_ecc  = pwdata[7:0];
                    default: ;
                endcase
                // wear counter lets software watch rewrites
                if (idx <= `BCL_IDX_CLOCK_ECC && st_reg.writes != 16'hffff)
                    st_next.writes = st_reg.writes + 16'h0001;
            end else if (hit) begin
                case (idx)
                    `BCL_IDX_DRIVE_LOW:    st_next.rdata = byte_word(st_reg.latch.drive_low);
                    `BCL_IDX_DRIVE_HIGH:   st_next.rdata = byte_word(st_reg.latch.drive_high);
                    `BCL_IDX_PIN_DEBUG:    st_next.rdata = byte_word(st_reg.latch.pin_debug);
                    `BCL_IDX_CLOCK_ECC:    st_next.rdata = byte_word(st_reg.latch.clock_ecc);
                    `BCL_IDX_ACTIVE_LOW:   st_next.rdata = byte_word(st_reg.snap.drive_low);
                    `BCL_IDX_ACTIVE_HIGH:  st_next.rdata = byte_word(st_reg.snap.drive_high);
                    `BCL_IDX_ACTIVE_PIN:   st_next.rdata = byte_word(st_reg.snap.pin_debug);
                    `BCL_IDX_ACTIVE_CLOCK: st_next.rdata = byte_word(st_reg.snap.clock_ecc);
                    `BCL_IDX_STATUS:       st_next.rdata = {15'h0000, st_reg.valid,
                                                            st_reg.writes};
                    default:               st_next.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // latch array keeps its contents across reset in silicon; here it
    // restarts at factory defaults on every presetn assertion as a limitation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg                 <= '0;
            st_reg.state           <= BCL_ST_RESET;
            st_reg.latch.drive_low <= `BCL_DEF_DRIVE_LOW;
            st_reg.latch.drive_high<= `BCL_DEF_DRIVE_HIGH;
            st_reg.latch.pin_debug <= `BCL_DEF_PIN_DEBUG;
            st_reg.latch.clock_ecc <= `BCL_DEF_CLOCK_ECC;
            st_reg.mhz             <= `BCL_BOOT_MHZ_SLOW;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata         = st_reg.rdata;
    assign pready         = st_reg.ready;
    assign pslverr        = st_reg.err;
    assign cfg_active     = st_reg.cfg;
    assign cfg_valid      = st_reg.valid;
    assign boot_clock_mhz = st_reg.mhz;
    // helper for the checks: a write in its first access cycle
    assign wr_acc         = acc && pwrite;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_cfg_held_stable: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |=> $stable(cfg_active))
        else $error("active configuration changed without reset");
    a_valid_after_load: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_reg.state == BCL_ST_RUN) |=> cfg_valid)
        else $error("configuration not applied after load");
    a_boot_speed_map: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> boot_clock_mhz == (cfg_active.boot_clock_speed ? 8'h30 : 8'h0c))
        else $error("boot clock frequency mismatch");
    a_dbg_port_field: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> cfg_active.debug_port_select == st_reg.snap.clock_ecc[2:1])
        else $error("debug port select mismatch");
    a_ext_reset_bit: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> cfg_active.external_reset_pin_select == st_reg.snap.pin_debug[7])
        else $error("reset pin select mismatch");
    a_debug_access_bit: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> cfg_active.debug_access_enable == st_reg.snap.pin_debug[6])
        else $error("debug access mismatch");
    a_ecc_phase_bits: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> {cfg_active.digital_clock_phase_delay, cfg_active.spare_flash_ecc_enable}
                      == {st_reg.snap.clock_ecc[7:4], st_reg.snap.clock_ecc[3]})
        else $error("ecc or phase field mismatch");
    a_port_drive_map: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> cfg_active.port_reset_drive_mode[5] == st_reg.snap.drive_high[3:2])
        else $error("port drive mode mismatch");
    a_phase_field: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> cfg_active.digital_clock_phase_delay == st_reg.snap.clock_ecc[7:4])
        else $error("phase delay mismatch");
    a_apb_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not single cycle");

    // ----------------------------------------------------------------
    // checks: port drive fields
    // ----------------------------------------------------------------
    // one check per port except port 5 (a_port_drive_map above), so a swapped bit pair shows up by its name
    a_port0_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[0] == st_reg.snap.drive_low[1:0])
        else $error("port 0 drive mode mismatch");

    a_port1_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[1] == st_reg.snap.drive_low[3:2])
        else $error("port 1 drive mode mismatch");

    a_port2_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[2] == st_reg.snap.drive_low[5:4])
        else $error("port 2 drive mode mismatch");

    a_port3_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[3] == st_reg.snap.drive_low[7:6])
        else $error("port 3 drive mode mismatch");

    a_port4_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[4] == st_reg.snap.drive_high[1:0])
        else $error("port 4 drive mode mismatch");

    a_port6_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[6] == st_reg.snap.drive_high[5:4])
        else $error("port 6 drive mode mismatch");

    a_port7_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[7] == st_reg.snap.drive_high[7:6])
        else $error("port 7 drive mode mismatch");

    a_port8_drive: assert property (cfg_valid |->
        cfg_active.port_reset_drive_mode[8] == st_reg.snap.pin_debug[1:0])
        else $error("port 8 drive mode mismatch");

    // ----------------------------------------------------------------
    // checks: reset sequence and holding
    // ----------------------------------------------------------------
    // the snapshot, not the live latches, must feed the configuration
    a_state_order: assert property (st_reg.state == BCL_ST_RESET |->
        ##1 st_reg.state == BCL_ST_LOAD)
        else $error("load step skipped after reset");

    a_load_to_run: assert property (st_reg.state == BCL_ST_LOAD |=>
        st_reg.state == BCL_ST_RUN && st_reg.snap == $past(st_reg.latch))
        else $error("snapshot not taken from latches");

    a_state_legal: assert property (
        st_reg.state != 2'b11)
        else $error("illegal sequencer state");

    a_snap_frozen: assert property (st_reg.state == BCL_ST_RUN |=>
        $stable(st_reg.snap))
        else $error("snapshot changed while running");

    a_valid_sticky: assert property (cfg_valid |=>
        cfg_valid)
        else $error("configuration valid dropped without reset");

    a_cfg_zero_idle: assert property (!cfg_valid |->
        cfg_active == '0)
        else $error("configuration shown before it is applied");

    a_mhz_slow_idle: assert property (!cfg_valid |->
        boot_clock_mhz == `BCL_BOOT_MHZ_SLOW)
        else $error("boot clock not slow before configuration");

    // ----------------------------------------------------------------
    // checks: register bus and latch array
    // ----------------------------------------------------------------
    // a write must land in one byte only; refused ones leave no trace
    a_ready_pulse: assert property (pready |=>
        !pready)
        else $error("ready held longer than one cycle");

    a_err_with_ready: assert property (pslverr |->
        pready)
        else $error("error flag without ready");

    a_err_reads_zero: assert property (pslverr |->
        prdata == 32'h0000_0000)
        else $error("refused access returned data");

    a_upper_rdata_zero: assert property (pready |->
        prdata[31:17] == 15'h0000)
        else $error("unused read data bits set");

    a_byte2_masked: assert property (
        (st_reg.latch.pin_debug & ~`BCL_BYTE2_USED_MASK) == 8'h00)
        else $error("unused bits of byte 2 set");

    a_latch_write_only: assert property (!wr_acc |=>
        $stable(st_reg.latch))
        else $error("latch array changed without a write");

    a_wr_lands_low: assert property (wr_acc && paddr == reg_addr(`BCL_IDX_DRIVE_LOW)
        |=> st_reg.latch.drive_low == $past(pwdata[7:0]))
        else $error("byte 0 write lost");

    a_wr_lands_high: assert property (wr_acc && paddr == reg_addr(`BCL_IDX_DRIVE_HIGH)
        |=> st_reg.latch.drive_high == $past(pwdata[7:0]))
        else $error("byte 1 write lost");

    a_wr_lands_pin: assert property (wr_acc && paddr == reg_addr(`BCL_IDX_PIN_DEBUG)
        |=> st_reg.latch.pin_debug == ($past(pwdata[7:0]) & `BCL_BYTE2_USED_MASK))
        else $error("byte 2 write lost");

    a_wr_lands_clock: assert property (wr_acc && paddr == reg_addr(`BCL_IDX_CLOCK_ECC)
        |=> st_reg.latch.clock_ecc == $past(pwdata[7:0]))
        else $error("byte 3 write lost");

    a_snap_wr_err: assert property (wr_acc && paddr == reg_addr(`BCL_IDX_ACTIVE_LOW)
        |=> pslverr)
        else $error("snapshot write not refused");

    a_misaligned_err: assert property (acc && paddr[1:0] != 2'b00 |=>
        pslverr)
        else $error("misaligned access not refused");

    a_high_addr_err: assert property (acc && paddr[31:6] != 26'h0 |=>
        pslverr)
        else $error("out of range access not refused");

    a_refused_clean: assert property (wr_acc && paddr[31:6] != 26'h0 |=>
        $stable(st_reg.latch))
        else $error("refused write changed the latches");

    a_wr_count_sat: assert property (st_reg.writes == 16'hffff |=>
        st_reg.writes == 16'hffff)
        else $error("write counter wrapped");

    a_count_step: assert property (wr_acc && paddr == reg_addr(`BCL_IDX_DRIVE_LOW)
        && st_reg.writes != 16'hffff
        |=> st_reg.writes == $past(st_reg.writes) + 16'h0001)
        else $error("latch write not counted");
endmodule

// ===== testbench/bcl_testbench.sv
// self-checking bench for the boot configuration latch block
`timescale 1ns/1ps
`include "bcl_consts.svh"
module testbench;
    import bcl_pkg::*;
    logic        pclk;
    logic        presetn;
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    bcl_config_t cfg_active;
    logic        cfg_valid;
    logic [7:0]  boot_clock_mhz;
    int          n_fail;
    int          checks;
    int          cyc;
    bcl_config_t dflt;

    bcl_top uut (
        .pclk           (pclk),
        .presetn        (presetn),
        .paddr          (paddr),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .cfg_active     (cfg_active),
        .cfg_valid      (cfg_valid),
        .boot_clock_mhz (boot_clock_mhz)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #5 pclk = ~pclk;

    // ceiling well above the roughly 140 cycles the scenarios need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] adr(input logic [3:0] idx);
        return {26'h0, idx, 2'b00};
    endfunction

    // one transfer; entered just after a rising edge, leaves one idle edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) chk("pready", 64'h1, 64'h0);
        chk("wait states", 64'h2, n);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        chk("pready pulse", 1'b0, pready);
    endtask

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(what, {exp_err, exp}, {er, rd});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
        chk("write error flag", exp_err, er);
    endtask

    task automatic do_reset();
        int n;
        n = 0;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("valid in reset", 1'b0, cfg_valid);
        chk("speed in reset", `BCL_BOOT_MHZ_SLOW, boot_clock_mhz);
        presetn <= 1'b1;
        while (cfg_valid !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n = n + 1;
        end
        chk("valid after reset", 1'b1, cfg_valid);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        rd_chk("byte0", adr(`BCL_IDX_DRIVE_LOW), 32'h00, 1'b0);
        rd_chk("byte1", adr(`BCL_IDX_DRIVE_HIGH), 32'h00, 1'b0);
        rd_chk("byte2", adr(`BCL_IDX_PIN_DEBUG), 32'h40, 1'b0);
        rd_chk("byte3", adr(`BCL_IDX_CLOCK_ECC), 32'h0a, 1'b0);
        rd_chk("snap3", adr(`BCL_IDX_ACTIVE_CLOCK), 32'h0a, 1'b0);
        chk("cfg", dflt, cfg_active);
        chk("boot mhz", `BCL_BOOT_MHZ_SLOW, boot_clock_mhz);
    endtask

    task automatic t_write_hold();
        wr(adr(`BCL_IDX_DRIVE_LOW), 32'he4, 1'b0);
        wr(adr(`BCL_IDX_DRIVE_HIGH), 32'h1b, 1'b0);
        wr(adr(`BCL_IDX_PIN_DEBUG), 32'hff, 1'b0);
        wr(adr(`BCL_IDX_CLOCK_ECC), 32'ha5, 1'b0);
        rd_chk("byte0 new", adr(`BCL_IDX_DRIVE_LOW), 32'he4, 1'b0);
        rd_chk("byte2 new", adr(`BCL_IDX_PIN_DEBUG), 32'hc3, 1'b0);
        rd_chk("byte3 new", adr(`BCL_IDX_CLOCK_ECC), 32'ha5, 1'b0);
        rd_chk("snap0 held", adr(`BCL_IDX_ACTIVE_LOW), 32'h00, 1'b0);
        rd_chk("status", adr(`BCL_IDX_STATUS), 32'h10004, 1'b0);
        chk("cfg held", dflt, cfg_active);
        chk("boot mhz held", `BCL_BOOT_MHZ_SLOW, boot_clock_mhz);
    endtask

    task automatic t_refuse();
        rd_chk("unmapped", adr(4'h9), 32'h0, 1'b1);
        rd_chk("misaligned", 32'h2, 32'h0, 1'b1);
        rd_chk("high addr", 32'h40, 32'h0, 1'b1);
        wr(adr(`BCL_IDX_ACTIVE_HIGH), 32'hff, 1'b1);
        rd_chk("snap1 kept", adr(`BCL_IDX_ACTIVE_HIGH), 32'h00, 1'b0);
        chk("cfg kept", dflt, cfg_active);
    endtask

    task automatic t_rereset();
        do_reset();
        @(posedge pclk);
        rd_chk("byte3 again", adr(`BCL_IDX_CLOCK_ECC), 32'h0a, 1'b0);
        rd_chk("snap2 again", adr(`BCL_IDX_ACTIVE_PIN), 32'h40, 1'b0);
        chk("cfg again", dflt, cfg_active);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        pclk    = 1'b0;
        presetn = 1'b0;
        paddr   = 32'h0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        pwdata  = 32'h0;
        n_fail  = 0;
        checks  = 0;
        cyc     = 0;
        dflt    = '0;
        dflt.debug_access_enable    = 1'b1;
        dflt.debug_port_select      = BCL_DBG_JTAG4;
        dflt.spare_flash_ecc_enable = 1'b1;
        @(posedge pclk);
        do_reset();
        @(posedge pclk);
        t_defaults();
        t_write_hold();
        t_refuse();
        t_rereset();
        stop_test();
    end
endmodule
